// *** inc/sat_pkg.sv ***
// How it works
// (R01) unsplit: 16-bit count, 0xffff wrap reloads both bytes and sets high flag
// (R02) cpu timer enable plus high flag raises the interrupt request
// (R03) unsplit: low flag requests interrupt too when low-byte enable is set
// (R04) split: two 8-bit counters, each reloading from its own reload byte
// (R05) run bit gates whole timer unsplit; split it gates only the high byte
// (R06) byte clock: system clock if its select is 1, else /12 or oscillator /8
// (R07) high wrap sets high flag, low wrap sets low flag; split high wrap interrupts
// (R08) split with low-byte enable: either counter overflow requests interrupt
// (R09) flags are only cleared by software, never by hardware
// (R10) low flag sets on every low-byte wrap in every mode
// (R11) capture every 8 source cycles; source 0 is rtc oscillator, 1 external
// (R12) capture copies the 16-bit count into reload bytes and sets high flag
// (R13) control bit 4 enables capture mode
// (R14) external select 0 picks system clock /12, 1 picks the /8 oscillator clock
// (R15) counted /8 clock: external oscillator if source bit 0, rtc if 1
// (R16) split: one external select for both bytes, per-byte system clock select
// (R17) external oscillator tick is synchronised to the system clock
// (R18) software should keep low-byte enable clear in 16-bit mode
// (R19) software should capture in 16-bit mode with a fast counting clock
// (R20) control layout: flags, low irq en, capture en, split, run, source, ext select
// (R21) count bytes read and write the live count; count and reload reset to zero
// (R22) clock control bit 5 high select, bit 4 low select; high ignored unsplit
// (R23) unsplit: low select clocks the whole counter; high byte moves on carry
// (R24) software write sets or clears either flag and requests interrupt likewise
package sat_pkg;
	// ==========================================
	// register addresses
	localparam logic [7:0] SAT_ADDR_CKCTL = 8'h8e;
	localparam logic [7:0] SAT_ADDR_CTRL = 8'hc8;
	localparam logic [7:0] SAT_ADDR_RLL = 8'hca;
	localparam logic [7:0] SAT_ADDR_RLH = 8'hcb;
	localparam logic [7:0] SAT_ADDR_CNTL = 8'hcc;
	localparam logic [7:0] SAT_ADDR_CNTH = 8'hcd;
	// ==========================================
	// field positions in the clock control register
	localparam int SAT_BIT_HI_CLKSEL = 5;
	localparam int SAT_BIT_LO_CLKSEL = 4;
	// ==========================================
	// reset values and counts
	localparam logic [7:0] SAT_CTRL_RST = 8'h00;
	localparam logic [7:0] SAT_BYTE_RST = 8'h00;
	localparam logic [1:0] SAT_CKSEL_RST = 2'h0;
	localparam logic [7:0] SAT_BYTE_MAX = 8'hff;
	localparam logic [3:0] SAT_DIV12_LAST = 4'hb;
	localparam logic [2:0] SAT_DIV8_LAST = 3'h7;
	// ==========================================
	// types
	typedef struct packed {
		logic high_overflow_flag;
		logic low_overflow_flag;
		logic low_byte_irq_enable;
		logic capture_enable;
		logic split_mode;
		logic run_control;
		logic capture_source_select;
		logic external_clock_select;
	} sat_ctrl_t;
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic [7:0] wdata;
	} sat_sfr_req_t;
endpackage : sat_pkg

// *** rtl/sat_osc_div8.sv ***
`timescale 1ns/100ps
// ==========================================
// oscillator divide by 8, synchronised to the system clock
module sat_osc_div8 (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic osc_i,
	output logic tick_o
);
	import sat_pkg::*;
	logic meta_q;
	logic sync_q;
	logic last_q;
	logic [2:0] edge_cnt_q;
	// first stage feeds only the second stage
	always_ff @(posedge clk_i) begin // see (R17)
		if (srst_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= osc_i;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end
	// oscillator must run below half the system clock or edges are lost
	always_ff @(posedge clk_i) begin // see (R11)
		if (srst_i) begin
			edge_cnt_q <= 3'h0;
			tick_o <= 1'b0;
		end else begin
			tick_o <= 1'b0;
			if (sync_q && !last_q) begin
				edge_cnt_q <= edge_cnt_q + 3'h1;
				tick_o <= (edge_cnt_q == SAT_DIV8_LAST);
			end
		end
	end
endmodule : sat_osc_div8

// *** rtl/sat_timer.sv ***
`timescale 1ns/100ps
// ==========================================
// split auto-reload timer with capture
module sat_timer (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire sat_pkg::sat_sfr_req_t sfr_req_i,
	input wire logic cpu_timer_irq_enable_i,
	input wire logic ext_osc_i,
	input wire logic rtc_osc_i,
	output logic [7:0] sfr_rdata_o,
	output logic irq_o
);
	import sat_pkg::*;

	// ==========================================
	// state
	sat_ctrl_t ctrl_q;
	logic [1:0] cksel_q;
	logic [7:0] rl_lo_q;
	logic [7:0] rl_hi_q;
	logic [7:0] cnt_lo_q;
	logic [7:0] cnt_hi_q;
	logic [3:0] div12_q;
	logic tick12_q;
	logic ext_tick;
	logic rtc_tick;

	// ==========================================
	// register decode
	logic wr_ctrl;
	logic wr_cksel;
	logic wr_rll;
	logic wr_rlh;
	logic wr_cntl;
	logic wr_cnth;
	logic wr_cnt;
	assign wr_ctrl = sfr_req_i.wr && (sfr_req_i.addr == SAT_ADDR_CTRL);
	assign wr_cksel = sfr_req_i.wr && (sfr_req_i.addr == SAT_ADDR_CKCTL);
	assign wr_rll = sfr_req_i.wr && (sfr_req_i.addr == SAT_ADDR_RLL);
	assign wr_rlh = sfr_req_i.wr && (sfr_req_i.addr == SAT_ADDR_RLH);
	assign wr_cntl = sfr_req_i.wr && (sfr_req_i.addr == SAT_ADDR_CNTL);
	assign wr_cnth = sfr_req_i.wr && (sfr_req_i.addr == SAT_ADDR_CNTH);
	assign wr_cnt = wr_cntl || wr_cnth;

	// ==========================================
	// clock sources
	sat_osc_div8 u_ext_div8 (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.osc_i(ext_osc_i),
		.tick_o(ext_tick)
	);
	sat_osc_div8 u_rtc_div8 (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.osc_i(rtc_osc_i),
		.tick_o(rtc_tick)
	);

	always_ff @(posedge clk_i) begin // see (R06)
		if (srst_i) begin
			div12_q <= 4'h0;
			tick12_q <= 1'b0;
		end else begin
			div12_q <= (div12_q == SAT_DIV12_LAST) ? 4'h0 : div12_q + 4'h1;
			tick12_q <= (div12_q == SAT_DIV12_LAST);
		end
	end

	logic osc8_tick;
	logic xclk_tick;
	logic lo_tick;
	logic hi_tick;
	logic cap_evt;
	// the counted /8 clock is the opposite oscillator from the captured one
	assign osc8_tick = ctrl_q.capture_source_select ? rtc_tick : ext_tick; // see (R15)
	assign xclk_tick = ctrl_q.external_clock_select ? osc8_tick : tick12_q; // see (R14)
	// one external select serves both bytes, each byte may bypass it
	assign lo_tick = cksel_q[0] ? 1'b1 : xclk_tick; // see (R06) (R16)
	assign hi_tick = cksel_q[1] ? 1'b1 : xclk_tick; // see (R22)
	assign cap_evt = ctrl_q.capture_enable && // see (R13)
		(ctrl_q.capture_source_select ? ext_tick : rtc_tick); // see (R11)

	// ==========================================
	// counting
	logic lo_wrap;
	logic hi_wrap;
	logic lo_step;
	logic hi_step;
	assign lo_step = ctrl_q.split_mode ? lo_tick : (ctrl_q.run_control && lo_tick); // see (R05) (R23)
	assign hi_step = ctrl_q.split_mode ? (ctrl_q.run_control && hi_tick) : (lo_step && cnt_lo_q == SAT_BYTE_MAX);
	assign lo_wrap = lo_step && (cnt_lo_q == SAT_BYTE_MAX);
	assign hi_wrap = hi_step && (cnt_hi_q == SAT_BYTE_MAX);

	// a count write takes the whole cycle, so no step lands on a fresh value
	always_ff @(posedge clk_i) begin // see (R21)
		if (srst_i) begin
			cnt_lo_q <= SAT_BYTE_RST;
			cnt_hi_q <= SAT_BYTE_RST;
		end else if (wr_cnt) begin
			if (wr_cntl) begin
				cnt_lo_q <= sfr_req_i.wdata;
			end
			if (wr_cnth) begin
				cnt_hi_q <= sfr_req_i.wdata;
			end
		end else if (ctrl_q.split_mode) begin
			if (lo_wrap) begin
				cnt_lo_q <= rl_lo_q; // see (R04)
			end else if (lo_step) begin
				cnt_lo_q <= cnt_lo_q + 8'h01;
			end
			if (hi_wrap) begin
				cnt_hi_q <= rl_hi_q; // see (R04)
			end else if (hi_step) begin
				cnt_hi_q <= cnt_hi_q + 8'h01;
			end
		end else if (hi_wrap) begin
			cnt_lo_q <= rl_lo_q; // see (R01)
			cnt_hi_q <= rl_hi_q;
		end else if (lo_step) begin
			cnt_lo_q <= cnt_lo_q + 8'h01;
			if (hi_step) begin
				cnt_hi_q <= cnt_hi_q + 8'h01; // see (R23)
			end
		end
	end

	// ==========================================
	// reload bytes; a capture beats a software write in the same cycle
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rl_lo_q <= SAT_BYTE_RST;
			rl_hi_q <= SAT_BYTE_RST;
		end else if (cap_evt) begin
			rl_lo_q <= cnt_lo_q; // see (R12)
			rl_hi_q <= cnt_hi_q;
		end else begin
			if (wr_rll) begin
				rl_lo_q <= sfr_req_i.wdata;
			end
			if (wr_rlh) begin
				rl_hi_q <= sfr_req_i.wdata;
			end
		end
	end

	// ==========================================
	// control and clock select
	sat_ctrl_t ctrl_wr;
	assign ctrl_wr = sat_ctrl_t'(sfr_req_i.wdata); // see (R20)
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctrl_q <= sat_ctrl_t'(SAT_CTRL_RST);
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= ctrl_wr; // see (R24)
			end
			// a hardware set wins over a clear written in the same cycle
			if (hi_wrap || cap_evt) begin
				ctrl_q.high_overflow_flag <= 1'b1; // see (R07) (R09) (R12)
			end
			if (lo_wrap) begin
				ctrl_q.low_overflow_flag <= 1'b1; // see (R10)
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cksel_q <= SAT_CKSEL_RST;
		end else if (wr_cksel) begin
			cksel_q <= {sfr_req_i.wdata[SAT_BIT_HI_CLKSEL], sfr_req_i.wdata[SAT_BIT_LO_CLKSEL]};
		end
	end

	// ==========================================
	// interrupt request follows the enabled flags, so it stays until software clears them or an enable drops
	always_ff @(posedge clk_i) begin // see (R02) (R03) (R07) (R08)
		if (srst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= cpu_timer_irq_enable_i && (ctrl_q.high_overflow_flag ||
				(ctrl_q.low_byte_irq_enable && ctrl_q.low_overflow_flag));
		end
	end

	// ==========================================
	// read data, one cycle after the address; unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sfr_rdata_o <= 8'h00;
		end else begin
			case (sfr_req_i.addr)
				SAT_ADDR_CTRL: sfr_rdata_o <= ctrl_q;
				SAT_ADDR_CKCTL: begin
					sfr_rdata_o <= 8'h00;
					sfr_rdata_o[SAT_BIT_HI_CLKSEL] <= cksel_q[1];
					sfr_rdata_o[SAT_BIT_LO_CLKSEL] <= cksel_q[0];
				end
				SAT_ADDR_RLL: sfr_rdata_o <= rl_lo_q;
				SAT_ADDR_RLH: sfr_rdata_o <= rl_hi_q;
				SAT_ADDR_CNTL: sfr_rdata_o <= cnt_lo_q; // see (R21)
				SAT_ADDR_CNTH: sfr_rdata_o <= cnt_hi_q;
				default: sfr_rdata_o <= 8'h00;
			endcase
		end
	end

	// ==========================================
	// assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	logic quiet;
	assign quiet = !sfr_req_i.wr;

	property p_wrap16;
		!ctrl_q.split_mode && ctrl_q.run_control && lo_tick && {cnt_hi_q, cnt_lo_q} == 16'hffff && !wr_cnt
		|=> {cnt_hi_q, cnt_lo_q} == {$past(rl_hi_q), $past(rl_lo_q)} && ctrl_q.high_overflow_flag
			&& ctrl_q.low_overflow_flag;
	endproperty
	a_wrap16: assert property (p_wrap16) else $error("16-bit wrap did not reload and flag"); // see (R01) (R10)

	property p_irq_high;
		cpu_timer_irq_enable_i && ctrl_q.high_overflow_flag |=> irq_o;
	endproperty
	a_irq_high: assert property (p_irq_high) else $error("high flag did not request interrupt"); // see (R02)

	property p_irq_low;
		cpu_timer_irq_enable_i && ctrl_q.low_byte_irq_enable && ctrl_q.low_overflow_flag |=> irq_o;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("low flag did not request interrupt"); // see (R03) (R08)

	property p_no_irq;
		!cpu_timer_irq_enable_i |=> !irq_o;
	endproperty
	a_no_irq: assert property (p_no_irq) else $error("interrupt without cpu enable"); // see (R02)

	property p_split_lo;
		ctrl_q.split_mode && lo_tick && cnt_lo_q == 8'hff && !wr_cnt
		|=> cnt_lo_q == $past(rl_lo_q) && ctrl_q.low_overflow_flag;
	endproperty
	a_split_lo: assert property (p_split_lo) else $error("split low byte did not reload"); // see (R04) (R10)

	property p_split_hi;
		ctrl_q.split_mode && ctrl_q.run_control && hi_tick && cnt_hi_q == 8'hff && !wr_cnt
		|=> cnt_hi_q == $past(rl_hi_q) && ctrl_q.high_overflow_flag;
	endproperty
	a_split_hi: assert property (p_split_hi) else $error("split high byte did not reload"); // see (R04) (R07)

	property p_stop16;
		!ctrl_q.split_mode && !ctrl_q.run_control && quiet |=> $stable({cnt_hi_q, cnt_lo_q});
	endproperty
	a_stop16: assert property (p_stop16) else $error("stopped timer moved"); // see (R05)

	property p_split_stop_hi;
		ctrl_q.split_mode && !ctrl_q.run_control && quiet |=> $stable(cnt_hi_q);
	endproperty
	a_split_stop_hi: assert property (p_split_stop_hi) else $error("split high moved while stopped"); // see (R05)

	property p_split_lo_runs;
		ctrl_q.split_mode && cksel_q[0] && cnt_lo_q != 8'hff && quiet |=> cnt_lo_q == $past(cnt_lo_q) + 8'h01;
	endproperty
	a_split_lo_runs: assert property (p_split_lo_runs) else $error("split low byte not counting"); // see (R05) (R06)

	property p_flag_kept;
		ctrl_q.high_overflow_flag && !wr_ctrl |=> ctrl_q.high_overflow_flag;
	endproperty
	a_flag_kept: assert property (p_flag_kept) else $error("high flag cleared by hardware"); // see (R09)

	property p_capture;
		cap_evt |=> {rl_hi_q, rl_lo_q} == $past({cnt_hi_q, cnt_lo_q}) && ctrl_q.high_overflow_flag;
	endproperty
	a_capture: assert property (p_capture) else $error("capture did not copy count"); // see (R12)

	property p_div12;
		tick12_q |=> !tick12_q [*8] ##1 !tick12_q [*3] ##1 tick12_q;
	endproperty
	a_div12: assert property (p_div12) else $error("divide by 12 spacing wrong"); // see (R06)

	property p_hi_ignored;
		!ctrl_q.split_mode && !cksel_q[0] && !xclk_tick && quiet |=> $stable({cnt_hi_q, cnt_lo_q});
	endproperty
	a_hi_ignored: assert property (p_hi_ignored) else $error("unsplit counter ran on high select"); // see (R22) (R23)

	c_wrap16: cover property (!ctrl_q.split_mode && hi_wrap);
	c_split_both: cover property (ctrl_q.split_mode && lo_wrap ##[1:300] hi_wrap);
	c_capture: cover property (cap_evt ##[1:1000] cap_evt);
	c_irq: cover property (!irq_o ##1 irq_o);
endmodule : sat_timer

// *** dv/testbench.sv ***
`timescale 1ns/100ps
module testbench;
	import sat_pkg::*;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	sat_sfr_req_t req = '0;
	logic cpu_en = 1'b1;
	logic ext_osc = 1'b0;
	logic rtc_osc = 1'b0;
	logic [7:0] rdata;
	logic irq;
	int err_count = 0;
	int checks = 0;
	int ocnt = 0;
	int e;
	logic [7:0] rd, hi, rl, rh, v;
	logic [15:0] cap [3];
	int exp_q[$];
	logic [7:0] amap [7] = '{8'h8e, 8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'h55};
	logic [7:0] pmode [3] = '{8'h04, 8'h05, 8'h07};
	int pper [3] = '{12, 64, 96};

	always #20 clk_i = ~clk_i;

	// ==========================================
	// oscillators: external period 8 cycles, real-time period 12 cycles
	always @(posedge clk_i) begin
		#1;
		ocnt = ocnt + 1;
		ext_osc = (ocnt % 8) < 4;
		rtc_osc = (ocnt % 12) < 6;
	end

	sat_timer dut (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.sfr_req_i(req),
		.cpu_timer_irq_enable_i(cpu_en),
		.ext_osc_i(ext_osc),
		.rtc_osc_i(rtc_osc),
		.sfr_rdata_o(rdata),
		.irq_o(irq)
	);

	// ==========================================
	// bus tasks, all entered one step after a rising edge
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: seen %h expected %h", $time, got, exp);
		end
	endtask : check

	// behavioural model: 16-bit up counter that reloads on the 0xffff wrap, one tick at a time
	function automatic int model16(input int cnt, input int n, input int rld);
		int m;
		m = cnt;
		for (int k = 0; k < n; k++)
			m = (m == 65535) ? rld : m + 1;
		return m;
	endfunction : model16

	// the strobe stays up after a write; the next read or idle drops it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req.addr = a;
		req.wr = 1'b1;
		req.wdata = d;
		@(posedge clk_i);
		#1;
	endtask : wr

	task automatic rdreg(input logic [7:0] a, output logic [7:0] d);
		req.wr = 1'b0;
		req.addr = a;
		@(posedge clk_i);
		#1;
		d = rdata;
	endtask : rdreg

	task automatic idle(input int n);
		req.wr = 1'b0;
		repeat (n) @(posedge clk_i);
		#1;
	endtask : idle

	task automatic print_verdict();
		if (err_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	// ==========================================
	// main sequence
	initial begin
		e = $urandom(47);
		idle(4);
		srst_i = 1'b0;
		wr(8'h55, 8'hff);
		for (int i = 0; i < 7; i++) begin
			rdreg(amap[i], rd);
			check(rd, 8'h00);
		end
		v = 8'($urandom) & 8'h22;
		wr(8'hc8, v);
		rdreg(8'hc8, rd);
		check(rd, v);
		// flags written by software raise the request like hardware does
		wr(8'hc8, 8'h80);
		idle(2);
		check(irq, 1'b1);
		wr(8'hc8, 8'h40);
		idle(2);
		check(irq, 1'b0);
		wr(8'hc8, 8'h60);
		idle(2);
		check(irq, 1'b1);
		// 16-bit wrap lands on the stop edge, so the set must beat the cleared write
		rl = 8'($urandom);
		rh = 8'($urandom);
		wr(8'h8e, 8'h10);
		wr(8'hca, rl);
		wr(8'hcb, rh);
		wr(8'hcc, 8'hfe);
		wr(8'hcd, 8'hff);
		wr(8'hc8, 8'h04);
		idle(1);
		wr(8'hc8, 8'h00);
		rdreg(8'hcc, rd);
		rdreg(8'hcd, hi);
		check({hi, rd}, 16'(model16(16'hfffe, 2, {rh, rl})));
		rdreg(8'hc8, rd);
		check(rd, 8'hc0);
		check(irq, 1'b1);
		cpu_en = 1'b0;
		idle(2);
		check(irq, 1'b0);
		cpu_en = 1'b1;
		// split: low runs without run bit, high stays frozen until the run bit is set
		wr(8'h8e, 8'h30);
		wr(8'hca, 8'haa);
		wr(8'hcb, 8'hbb);
		wr(8'hcc, 8'hfe);
		wr(8'hcd, 8'hf0);
		wr(8'hc8, 8'h08);
		idle(1);
		wr(8'hc8, 8'h00);
		rdreg(8'hcc, rd);
		check(rd, 8'haa);
		rdreg(8'hcd, rd);
		check(rd, 8'hf0);
		rdreg(8'hc8, rd);
		check(rd, 8'h40);
		check(irq, 1'b0);
		wr(8'hc8, 8'h68);
		idle(2);
		check(irq, 1'b1);
		wr(8'hc8, 8'h00);
		wr(8'hcc, 8'h00);
		wr(8'hcd, 8'hfe);
		wr(8'hc8, 8'h0c);
		idle(1);
		wr(8'hc8, 8'h00);
		rdreg(8'hcd, rd);
		check(rd, 8'hbb);
		rdreg(8'hcc, rd);
		check(rd, 8'h02);
		rdreg(8'hc8, rd);
		check(rd, 8'h80);
		check(irq, 1'b1);
		wr(8'hc8, 8'h00);
		// prescaled sources over 960 cycles; high select set but ignored unsplit
		for (int i = 0; i < 3; i++) begin
			wr(8'h8e, 8'h20);
			wr(8'hcc, 8'h00);
			wr(8'hcd, 8'h00);
			wr(8'hc8, pmode[i]);
			idle(959);
			wr(8'hc8, 8'h00);
			rdreg(8'hcc, rd);
			e = 960 / pper[i];
			check(16'(int'(rd) >= e - 1 && int'(rd) <= e + 1), 16'h0001);
			rdreg(8'hcd, hi);
			check(hi, 8'h00);
		end
		// capture: successive captures differ by 8 source periods of system clock
		wr(8'h8e, 8'h10);
		for (int s = 0; s < 2; s++) begin
			v = 8'h14 | 8'(s << 1);
			wr(8'hc8, v);
			exp_q.push_back(8 * ((s == 1) ? 8 : 12));
			// the first capture may still come from the previous source, so it is skipped
			for (int j = 0; j < 3; j++) begin
				rd = 8'h00;
				for (int t = 0; t < 300 && rd[7] !== 1'b1; t++)
					rdreg(8'hc8, rd);
				check(16'(rd[7]), 16'h0001);
				if (rd[7] !== 1'b1)
					break;
				rdreg(8'hca, rd);
				rdreg(8'hcb, hi);
				cap[j] = {hi, rd};
				wr(8'hc8, v);
			end
			check(cap[2] - cap[1], 16'(exp_q.pop_front()));
		end
		wr(8'hc8, 8'h00);
		print_verdict();
	end
endmodule : testbench
